// ### logic/laic_counter.sv
// Integration window timer and two saturating result counters.
module laic_counter
    import laic_pkg::*;
(
    // Clock, reset, enable.
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clkEn,
    // Oscillator and converter pulses, asynchronous to core_clk.
    input wire logic oscIn,
    input wire laic_pkg::laic_pulse_t convPulse,
    // Settings.
    input wire logic [1:0] integTime,
    input wire logic highGain,
    // Results.
    output laic_pkg::laic_result_t dataRegs,
    output logic resultValid
);
    import laic_pkg::*;

    laic_state_t state_ff;
    laic_state_t nxt_state;
    laic_pulse_t pulseMeta_ff;
    laic_pulse_t pulseSync_ff;
    laic_pulse_t pulseSeen_ff;

    logic oscEdge;
    logic [CYC_W-1:0] windowLen;
    logic bbReq;
    logic irReq;

    // Two-stage synchronisers for the converter pulses; a third stage feeds edge detection only.
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pulseMeta_ff <= '0;
            pulseSync_ff <= '0;
            pulseSeen_ff <= '0;
        end
        else if (clkEn)
        begin
            pulseMeta_ff <= convPulse;
            pulseSync_ff <= pulseMeta_ff;
            pulseSeen_ff <= pulseSync_ff;
        end
    end

    // Oscillator rising edge is seen between synchronised stages 1 and 2 only.
    assign oscEdge = state_ff.oscSync[1] & ~state_ff.oscSync[2];
    assign bbReq = pulseSync_ff.broadbandPulse & ~pulseSeen_ff.broadbandPulse;
    assign irReq = pulseSync_ff.infraredPulse & ~pulseSeen_ff.infraredPulse;

    // Window length from the settings latched at window start.
    always_comb
    begin
        case (state_ff.itimeLatched)
            ITIME_SHORT: windowLen = CYC_SHORT;
            ITIME_MID: windowLen = CYC_MID;
            ITIME_LONG: windowLen = CYC_LONG;
            default: windowLen = CYC_LONG;
        endcase
    end

    // Next-state logic: shared timer, paced counters and result transfer.
    always_comb
    begin
        logic paceSlot;
        logic bbStep;
        logic irStep;
        nxt_state = state_ff;
        paceSlot = 1'b0;
        bbStep = 1'b0;
        irStep = 1'b0;
        nxt_state.oscSync = {state_ff.oscSync[1:0], oscIn};
        nxt_state.done = 1'b0;
        // Requests are remembered until the next pacing slot; further requests before that slot merge into the one held.
        if (bbReq)
            nxt_state.bbPre = state_ff.bbPre | 5'h01;
        if (irReq)
            nxt_state.irPre = state_ff.irPre | 5'h01;
        if (oscEdge)
        begin
            nxt_state.cycles = state_ff.cycles + 19'h0_0001;
            nxt_state.pace = ~state_ff.pace;
            paceSlot = state_ff.pace;
            if (paceSlot)
            begin
                // Low gain passes one converter count in sixteen.
                // The prescaler needs four bits; three would pass one count in eight.
                bbStep = state_ff.bbPre[0] & (state_ff.gainLatched | (state_ff.bbPre[4:1] == LOW_GAIN_DIV));
                irStep = state_ff.irPre[0] & (state_ff.gainLatched | (state_ff.irPre[4:1] == LOW_GAIN_DIV));
                if (state_ff.bbPre[0])
                    nxt_state.bbPre = {state_ff.bbPre[4:1] + 4'h1, bbReq};
                if (state_ff.irPre[0])
                    nxt_state.irPre = {state_ff.irPre[4:1] + 4'h1, irReq};
                // The first two slots of each window are swallowed by the fixed offset.
                if (state_ff.offsetLeft != '0)
                begin
                    nxt_state.offsetLeft = state_ff.offsetLeft - 16'h0001;
                    bbStep = 1'b0;
                    irStep = 1'b0;
                end
                if (bbStep && state_ff.bbCount != CNT_MAX)
                    nxt_state.bbCount = state_ff.bbCount + 16'h0001;
                if (irStep && state_ff.irCount != CNT_MAX)
                    nxt_state.irCount = state_ff.irCount + 16'h0001;
            end
            if (state_ff.cycles + 19'h0_0001 == windowLen)
            begin
                // Both counts are published in one cycle, so no reader sees a mix.
                nxt_state.results.broadbandChannel = nxt_state.bbCount;
                nxt_state.results.infraredChannel = nxt_state.irCount;
                nxt_state.done = 1'b1;
                nxt_state.cycles = '0;
                nxt_state.pace = 1'b0;
                nxt_state.offsetLeft = CNT_OFFSET;
                nxt_state.bbCount = '0;
                nxt_state.irCount = '0;
                nxt_state.bbPre = '0;
                nxt_state.irPre = '0;
                // Settings for the next window are sampled here and nowhere else.
                nxt_state.itimeLatched = integTime;
                nxt_state.gainLatched = highGain;
            end
        end
    end

    // State register; settings only take effect at a window boundary.
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_ff <= '0;
            state_ff.offsetLeft <= CNT_OFFSET;
            // The first window is short and high gain, so a result appears soon after reset.
            state_ff.itimeLatched <= ITIME_SHORT;
            state_ff.gainLatched <= 1'b1;
        end
        else if (clkEn)
            state_ff <= nxt_state;
    end

    // Outputs come straight from the state register, so they never glitch.
    assign dataRegs = state_ff.results;
    assign resultValid = state_ff.done;

    // Checks on the counter's own behaviour.
    // They are disabled while reset is low, as the state is then forced.

    // The shared timer never reaches the window length.
    a_window_length: assert property (@(posedge core_clk) disable iff (!rst_b)
        state_ff.cycles < windowLen)
        else $error("Window counter passed its length.");

    // The timer wraps on the edge that completes the window.
    a_cycle_wrap: assert property (@(posedge core_clk) disable iff (!rst_b)
        ($past(clkEn) && $past(oscEdge) && $past(state_ff.cycles) + 19'h0_0001 == $past(windowLen))
        |-> state_ff.cycles == '0)
        else $error("Window did not end at its length.");

    // A broadband step only follows a pacing slot.
    a_pace_limit: assert property (@(posedge core_clk) disable iff (!rst_b)
        (clkEn && state_ff.bbCount != $past(state_ff.bbCount) && state_ff.cycles != '0)
        |-> $past(state_ff.pace))
        else $error("Broadband counter stepped outside a pacing slot.");

    // An infrared step only follows a pacing slot.
    a_ir_pace_limit: assert property (@(posedge core_clk) disable iff (!rst_b)
        (clkEn && state_ff.irCount != $past(state_ff.irCount) && state_ff.cycles != '0)
        |-> $past(state_ff.pace))
        else $error("Infrared counter stepped outside a pacing slot.");

    // The broadband count holds at full scale.
    a_count_saturate: assert property (@(posedge core_clk) disable iff (!rst_b)
        ($past(state_ff.bbCount) == CNT_MAX && state_ff.cycles != '0) |-> state_ff.bbCount == CNT_MAX)
        else $error("Broadband counter wrapped.");

    // Published results only move together with the valid pulse.
    a_result_atomic: assert property (@(posedge core_clk) disable iff (!rst_b)
        !state_ff.done |=> (dataRegs == $past(dataRegs)) || resultValid)
        else $error("Results changed without a transfer.");

    // A transfer always restarts the window from zero.
    a_restart_window: assert property (@(posedge core_clk) disable iff (!rst_b)
        resultValid |-> state_ff.cycles == '0 && state_ff.bbCount == '0 && state_ff.irCount == '0)
        else $error("New window did not start after transfer.");

    // The window length setting is taken at the transfer.
    a_time_latch: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(state_ff.done) |-> state_ff.itimeLatched == $past(integTime))
        else $error("Window setting not taken at transfer.");

    // No count is made while the offset is being swallowed.
    a_offset_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
        state_ff.offsetLeft != '0 |-> state_ff.bbCount == '0 && state_ff.irCount == '0)
        else $error("Count advanced during offset.");

    // Every new window reloads the full offset.
    a_offset_reload: assert property (@(posedge core_clk) disable iff (!rst_b)
        resultValid |-> state_ff.offsetLeft == CNT_OFFSET)
        else $error("Offset not reloaded at window start.");

    // The infrared count holds at full scale.
    a_infrared_sat: assert property (@(posedge core_clk) disable iff (!rst_b)
        ($past(state_ff.irCount) == CNT_MAX && state_ff.cycles != '0) |-> state_ff.irCount == CNT_MAX)
        else $error("Infrared counter wrapped.");

    // The gain setting is taken at the transfer.
    a_gain_latch: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(state_ff.done) |-> state_ff.gainLatched == $past(highGain))
        else $error("Gain setting not taken at transfer.");

    // At low gain a broadband step needs a full prescaler.
    a_low_gain_step: assert property (@(posedge core_clk) disable iff (!rst_b)
        (!state_ff.gainLatched && state_ff.bbCount != $past(state_ff.bbCount) && state_ff.cycles != '0)
        |-> $past(state_ff.bbPre[4:1]) == LOW_GAIN_DIV)
        else $error("Low gain counted too often.");

    // The shared timer only moves on an oscillator edge.
    a_cycle_step: assert property (@(posedge core_clk) disable iff (!rst_b)
        (clkEn && !oscEdge) |=> state_ff.cycles == $past(state_ff.cycles))
        else $error("Shared timer moved without an oscillator edge.");

endmodule : laic_counter

// ### shared/laic_pkg.sv
// Package of constants and types for the light integration counter.
package laic_pkg;

    localparam int CYC_W = 19;
    localparam int CNT_W = 16;
    localparam logic [CYC_W-1:0] CYC_UNIT = 19'h0_0396;
    localparam logic [CYC_W-1:0] CYC_SHORT = 19'h0_2772;
    localparam logic [CYC_W-1:0] CYC_MID = 19'h1_2276;
    localparam logic [CYC_W-1:0] CYC_LONG = 19'h4_82AC;
    localparam int OSC_NOMINAL_KHZ = 735;
    localparam logic [CNT_W-1:0] CNT_OFFSET = 16'h0002;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
    localparam logic [3:0] LOW_GAIN_DIV = 4'hF;
    localparam logic [1:0] ITIME_SHORT = 2'h0;
    localparam logic [1:0] ITIME_MID = 2'h1;
    localparam logic [1:0] ITIME_LONG = 2'h2;

    // Converter pulse pair: one request per channel.
    typedef struct packed {
        logic broadbandPulse;
        logic infraredPulse;
    } laic_pulse_t;

    // Result pair published to the data registers.
    typedef struct packed {
        logic [CNT_W-1:0] broadbandChannel;
        logic [CNT_W-1:0] infraredChannel;
    } laic_result_t;

    // State of the counter block, apart from the converter pulse synchronisers.
    typedef struct packed {
        logic [2:0] oscSync;
        logic [CYC_W-1:0] cycles;
        logic pace;
        logic [CNT_W-1:0] offsetLeft;
        logic [CNT_W-1:0] bbCount;
        logic [CNT_W-1:0] irCount;
        logic [4:0] bbPre;
        logic [4:0] irPre;
        logic [1:0] itimeLatched;
        logic gainLatched;
        laic_result_t results;
        logic done;
    } laic_state_t;

endpackage : laic_pkg

// ### verification/laic_conv_model.sv
// Behavioural oscillator and converter pulse source facing the integration counter.
module laic_conv_model
    import laic_pkg::*;
(
    // Clock and channel light enables.
    input wire logic core_clk,
    input wire logic bbOn,
    input wire logic irOn,
    // Oscillator and converter pulses.
    output logic oscIn,
    output laic_pkg::laic_pulse_t convPulse
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] phase;
    // The oscillator runs fast at four core periods to keep windows short; edges stay off core_clk edges.
    initial
    begin
        oscIn = 1'b0;
        phase = 2'h0;
        convPulse = '0;
        #5;
        forever #8 oscIn = ~oscIn;
    end
    // Levels toggle every third cycle, so each level meets the synchroniser's hold time.
    // A dark channel returns low, so no edge is left pending.
    always @(negedge core_clk)
    begin
        phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
        if (phase == 2'h2)
        begin
            convPulse.broadbandPulse <= bbOn & ~convPulse.broadbandPulse;
            convPulse.infraredPulse <= irOn & ~convPulse.infraredPulse;
        end
    end
endmodule : laic_conv_model

// ### verification/light_adc_integration_counter_tb.sv
// Self-checking testbench for the light integration counter.
module light_adc_integration_counter_tb;
    import laic_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rst_b, clkEn, highGain, bbOn, irOn, oscIn, resultValid;
    logic [1:0] integTime;
    laic_pulse_t convPulse;
    laic_result_t dataRegs;
    int mismatches, n_tests, oscRises;
    laic_conv_model laic_conv_model_inst (.core_clk(core_clk), .bbOn(bbOn), .irOn(irOn), .oscIn(oscIn),
        .convPulse(convPulse));
    laic_counter laic_counter_inst (.core_clk(core_clk), .rst_b(rst_b), .clkEn(clkEn), .oscIn(oscIn),
        .convPulse(convPulse), .integTime(integTime), .highGain(highGain), .dataRegs(dataRegs),
        .resultValid(resultValid));
    // Clock generator.
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // Oscillator periods are counted to time the first two windows.
    always @(posedge oscIn) oscRises++;
    // Compares one value and records any difference.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expected);
        n_tests++;
        if (seen !== expected)
        begin
            mismatches++;
            $display("wrong value %s expected %0h seen %0h", what, expected, seen);
        end
    endtask : check
    // Waits at falling edges for the result pulse, with a bound so a stuck timer cannot hang the run.
    task automatic wait_result(input int limit);
        int i;
        i = 0;
        while (resultValid !== 1'b1 && i < limit)
        begin
            @(negedge core_clk);
            i++;
        end
        check("result pulse", {31'h0, resultValid}, 32'h1);
    endtask : wait_result
    // Reset clears the results; both channels are lit for the first window, which is short and high gain.
    task automatic test_reset();
        check("reset data", dataRegs, 32'h0);
        check("reset pulse", {31'h0, resultValid}, 32'h0);
        bbOn = 1'b1;
        irOn = 1'b1;
        oscRises = 0;
        $display("test_reset done");
    endtask : test_reset
    // First window has a request in every slot and reaches its most, half of CYC_SHORT less CNT_OFFSET, on both channels.
    task automatic test_full_scale();
        wait_result(100_000);
        check("window length", oscRises, 32'(CYC_SHORT));
        check("broadband full", dataRegs.broadbandChannel, 32'(CYC_SHORT >> 1) - 32'(CNT_OFFSET));
        check("infrared full", dataRegs.infraredChannel, 32'(CYC_SHORT >> 1) - 32'(CNT_OFFSET));
        oscRises = 0;
        irOn = 1'b0;
        highGain = 1'b1;
        @(negedge core_clk);
        check("pulse width", {31'h0, resultValid}, 32'h0);
        $display("test_full_scale done");
    endtask : test_full_scale
    // Second window is low gain with broadband lit only: one sixteenth of the first window's count, infrared dark.
    task automatic test_low_gain();
        repeat (1000) @(negedge core_clk);
        check("held data", dataRegs.broadbandChannel, 32'(CYC_SHORT >> 1) - 32'(CNT_OFFSET));
        wait_result(100_000);
        check("window restart", oscRises, 32'(CYC_SHORT));
        bbOn = 1'b0;
        check("infrared dark", {16'h0, dataRegs.infraredChannel}, 32'h0);
        check("low gain range", {31'h0, dataRegs.broadbandChannel < CNT_MAX}, 32'h1);
        check("low gain counts", {31'h0, dataRegs.broadbandChannel != 16'h0}, 32'h1);
        check("low gain scale", dataRegs.broadbandChannel, (32'(CYC_SHORT >> 1) - 32'(CNT_OFFSET)) >> 4);
        $display("test_low_gain done");
    endtask : test_low_gain
    // Dark window: old results stay readable until the next transfer replaces them.
    task automatic test_dark();
        repeat (1000) @(negedge core_clk);
        check("held data", dataRegs.broadbandChannel, (32'(CYC_SHORT >> 1) - 32'(CNT_OFFSET)) >> 4);
        wait_result(100_000);
        check("dark data", dataRegs, 32'h0);
        $display("test_dark done");
    endtask : test_dark
    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report
    // Main sequence.
    initial
    begin
        rst_b = 1'b0;
        clkEn = 1'b1;
        integTime = ITIME_SHORT;
        highGain = 1'b0;
        bbOn = 1'b0;
        irOn = 1'b0;
        repeat (3) @(negedge core_clk);
        rst_b = 1'b1;
        test_reset();
        test_full_scale();
        test_low_gain();
        test_dark();
        final_report();
    end
    // Watchdog sized above three short windows of about 161 us each.
    initial
    begin
        #600_000;
        mismatches++;
        final_report();
    end
endmodule : light_adc_integration_counter_tb
